// File: logic/ppg_interlock.sv
/*
  Pipeline protection interlock for a seven stage core pipeline.
  Tracks every in-flight instruction with one read and one write access
  and holds a reader in its read stage while an older instruction still
  has to write the same protected resource.
  Assumes decode offers one instruction a cycle with a valid/ready
  handshake and that all inputs come from logic on core_clk.
*/
`timescale 1ns/1ps
`include "ppg_regs.svh"

// Functional notes
// - Coarse status field write blocks other field tests
// - Indirect bits of the first two status regs use per-field protection
// - Same-group registers conflict and stall reader
// - Individual or different-group registers never conflict
// - Listed core registers are each protected alone
// - Each accumulator's three parts form a group
// - Transition pair one group, circular regs another
// - Block repeat and loop address registers grouped
// - Reader waits until grouped write has completed
// - Coefficient pointer write never delays aux read
// - Direct status naming and last two: coarse

module ppg_interlock
  import ppg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic issue_valid,
  input wire logic rd_en,
  input wire logic [5:0] rd_reg,
  input wire logic rd_direct,
  input wire logic [`PPG_FIELD_W-1:0] rd_field,
  input wire logic [2:0] rd_stage,
  input wire logic wr_en,
  input wire logic [5:0] wr_reg,
  input wire logic wr_direct,
  input wire logic [`PPG_FIELD_W-1:0] wr_field,
  input wire logic [2:0] wr_stage,
  output logic issue_ready,
  output logic [`PPG_STAGES-1:0] stage_valid,
  output logic [`PPG_STAGES-1:0] stage_hold,
  output logic [`PPG_CNT_W-1:0] stall_count
);

  // Lookup carriers for the incoming read and write
  ppg_map_if rd_map ();
  ppg_map_if wr_map ();

  // Pipeline contents, index is the stage
  ppg_slot_t [`PPG_STAGES-1:0] pipe_reg;
  ppg_slot_t [`PPG_STAGES-1:0] pipe_next;
  // Per-stage freeze for the current contents
  logic [`PPG_STAGES-1:0] hold_reg;
  logic [`PPG_STAGES-1:0] hold_next;
  // Registered copies that drive the outputs
  logic ready_reg;
  logic ready_next;
  logic [`PPG_STAGES-1:0] valid_reg;
  logic [`PPG_STAGES-1:0] valid_next;
  logic [`PPG_CNT_W-1:0] cnt_reg;
  logic [`PPG_CNT_W-1:0] cnt_next;
  // Incoming instruction as a slot
  ppg_slot_t incoming;

  // Drive the lookups from the decode fields
  assign rd_map.reg_id = ppg_reg_t'(rd_reg);
  assign rd_map.direct = rd_direct;
  assign rd_map.field = rd_field;
  assign wr_map.reg_id = ppg_reg_t'(wr_reg);
  assign wr_map.direct = wr_direct;
  assign wr_map.field = wr_field;

  // Read access lookup
  // one key per listed register
  ppg_map u_rd_map (
    .port (rd_map.mapper)
  );

  // Write access lookup
  // accumulator group keys
  ppg_map u_wr_map (
    .port (wr_map.mapper)
  );

  // Two accesses collide on the same resource and a shared field
  function automatic logic collide(input ppg_acc_t w, input ppg_acc_t r);
    logic same_key;
    logic overlap;
    // same group key means one resource
    same_key = (w.key == r.key);
    overlap = |(w.mask & r.mask);
    collide = same_key && overlap;
  endfunction

  // Stage freeze vector computed from a set of pipeline contents
  function automatic logic [`PPG_STAGES-1:0] hold_of(
    input ppg_slot_t [`PPG_STAGES-1:0] p
  );
    logic [`PPG_STAGES-1:0] stall;
    logic [`PPG_STAGES-1:0] h;
    stall = '0;
    // Reader sits in stage s; older instructions lie in stages above
    for (int s = 0; s < `PPG_STAGES - 1; s++)
    begin
      // only a reader in its own read stage is checked
      if (p[s].valid && p[s].rd.en && (p[s].rd.stage == ppg_stage_t'(3'(s))))
      begin
        for (int j = s + 1; j < `PPG_STAGES; j++)
        begin
          // write not yet past its write stage still pending
          if (p[j].valid && p[j].wr.en && (p[j].wr.stage >= ppg_stage_t'(3'(j))) &&
              collide(p[j].wr, p[s].rd))
          begin
            stall[s] = 1'b1;
          end
        end
      end
    end
    // A stalled stage also freezes every younger stage behind it
    h[`PPG_STAGES-1] = stall[`PPG_STAGES-1];
    for (int k = `PPG_STAGES - 2; k >= 0; k--)
    begin
      h[k] = stall[k] | h[k+1];
    end
    hold_of = h;
  endfunction

  // Build the incoming slot from decode and the lookups
  always_comb
  begin
    incoming = '0;
    incoming.valid = issue_valid;
    // coarse write mask covers every field of the register
    incoming.rd.en = issue_valid & rd_en;
    incoming.rd.stage = ppg_stage_t'(rd_stage);
    // direct naming yields a whole-register mask
    incoming.rd.key = rd_map.key;
    incoming.rd.mask = rd_map.mask;
    incoming.wr.en = issue_valid & wr_en;
    incoming.wr.stage = ppg_stage_t'(wr_stage);
    incoming.wr.key = wr_map.key;
    incoming.wr.mask = wr_map.mask;
  end

  // Advance the pipeline; frozen stages keep their contents
  always_comb
  begin
    pipe_next = pipe_reg;
    for (int k = 0; k < `PPG_STAGES; k++)
    begin
      // Frozen stage holds its instruction
      if (hold_reg[k])
      begin
        pipe_next[k] = pipe_reg[k];
      end
      // Decode takes the offered instruction when free
      else if (k == 0)
      begin
        pipe_next[k] = incoming;
      end
      // Bubble ahead of a frozen stage
      else if (hold_reg[k-1])
      begin
        pipe_next[k] = '0;
      end
      // Normal move one stage on
      else
      begin
        pipe_next[k] = pipe_reg[k-1];
      end
    end
  end

  // Freeze, ready, occupancy and stall counting for the next cycle
  always_comb
  begin
    // individual keys let an aux read pass a pointer write
    hold_next = hold_of(pipe_next);
    ready_next = ~hold_next[0];
    for (int k = 0; k < `PPG_STAGES; k++)
    begin
      valid_next[k] = pipe_next[k].valid;
    end
    // Count cycles in which any stage is frozen
    cnt_next = cnt_reg + `PPG_CNT_W'(|hold_reg);
  end

  // State registers
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pipe_reg <= '0;
      hold_reg <= `PPG_HOLD_RST;
      ready_reg <= `PPG_READY_RST;
      valid_reg <= `PPG_VALID_RST;
      cnt_reg <= `PPG_CNT_RST;
    end
    else
    begin
      pipe_reg <= pipe_next;
      hold_reg <= hold_next;
      ready_reg <= ready_next;
      valid_reg <= valid_next;
      cnt_reg <= cnt_next;
    end
  end

  // Outputs straight from flip-flops
  assign issue_ready = ready_reg;
  assign stage_valid = valid_reg;
  assign stage_hold = hold_reg;
  assign stall_count = cnt_reg;

  // Group codes for the transition, circular and loop registers
  // transition and circular groups live in the map
  // loop group likewise
  // Both lookups share one map module so read and write agree.

endmodule

// File: logic/ppg_map.sv
/*
  Protection map: turns a register access into a protected resource key
  and a field mask.
  Assumes purely combinational use on the core clock.
*/
`timescale 1ns/1ps
`include "ppg_regs.svh"

module ppg_map
  import ppg_pkg::*;
(
  ppg_map_if.mapper port
);

  // Lookup of key and mask
  always_comb
  begin
    port.key = '0;
    port.mask = '1;
    // Indirect bit access of the first two status registers: per field
    if ((port.reg_id <= ppg_r_stat1) && !port.direct)
    begin
      port.key = {1'b0, port.reg_id};
      port.mask = '0;
      port.mask[port.field] = 1'b1;
    end
    // Individually protected registers, whole-register mask
    else if (port.reg_id <= ppg_r_vec_host)
    begin
      port.key = {1'b0, port.reg_id};
    end
    // Accumulator groups, low/high/guard parts together
    else if (port.reg_id <= ppg_r_acc0_grd)
    begin
      port.key = {1'b1, `PPG_GRP_ACC0};
    end
    else if (port.reg_id <= ppg_r_acc1_grd)
    begin
      port.key = {1'b1, `PPG_GRP_ACC1};
    end
    else if (port.reg_id <= ppg_r_acc2_grd)
    begin
      port.key = {1'b1, `PPG_GRP_ACC2};
    end
    else if (port.reg_id <= ppg_r_acc3_grd)
    begin
      port.key = {1'b1, `PPG_GRP_ACC3};
    end
    else if (port.reg_id <= ppg_r_trans1)
    begin
      port.key = {1'b1, `PPG_GRP_TRANS};
    end
    else if (port.reg_id <= ppg_r_circ_startc)
    begin
      port.key = {1'b1, `PPG_GRP_CIRC};
    end
    // block repeat and loop addresses grouped
    else
    begin
      port.key = {1'b1, `PPG_GRP_LOOP};
    end
  end

endmodule

// File: logic/ppg_map_if.sv
/*
  Carrier between the interlock and its protection map lookup.
  Assumes ppg_pkg is compiled first.
*/
`timescale 1ns/1ps
`include "ppg_regs.svh"

interface ppg_map_if;
  import ppg_pkg::*;
  ppg_reg_t reg_id; // Register named by the access
  logic direct; // Access names the register itself
  logic [`PPG_FIELD_W-1:0] field; // Field index for status bits
  ppg_key_t key; // Protected resource
  logic [`PPG_MASK_W-1:0] mask; // Fields covered

  modport client (output reg_id, output direct, output field, input key, input mask);
  modport mapper (input reg_id, input direct, input field, output key, output mask);
endinterface

// File: logic/ppg_pkg.sv
/*
  Types of the pipeline protection interlock: stages, register
  identities, protection keys and pipeline slot contents.
  Assumes ppg_regs.svh is on the include path.
*/
`include "ppg_regs.svh"

package ppg_pkg;

  // Pipeline stages in program order
  typedef enum logic [2:0] {
    ppg_st_dec = 3'h0, ppg_st_addr = 3'h1, ppg_st_acc1 = 3'h2, ppg_st_acc2 = 3'h3,
    ppg_st_read = 3'h4, ppg_st_exec = 3'h5, ppg_st_write = 3'h6
  } ppg_stage_t;

  // Register identities; order matters to the protection map
  typedef enum logic [5:0] {
    ppg_r_stat0, ppg_r_stat1, ppg_r_stat2, ppg_r_stat3,
    ppg_r_aux0, ppg_r_aux1, ppg_r_aux2, ppg_r_aux3,
    ppg_r_aux4, ppg_r_aux5, ppg_r_aux6, ppg_r_aux7,
    ppg_r_tmp0, ppg_r_tmp1, ppg_r_tmp2, ppg_r_tmp3,
    ppg_r_coef_ptr, ppg_r_sys_sp, ppg_r_data_sp, ppg_r_rpt_src, ppg_r_rpt_cnt,
    ppg_r_int_en0, ppg_r_int_en1, ppg_r_dbg_en0, ppg_r_dbg_en1,
    ppg_r_int_flag0, ppg_r_int_flag1, ppg_r_vec_data, ppg_r_vec_host,
    ppg_r_acc0_lo, ppg_r_acc0_hi, ppg_r_acc0_grd,
    ppg_r_acc1_lo, ppg_r_acc1_hi, ppg_r_acc1_grd,
    ppg_r_acc2_lo, ppg_r_acc2_hi, ppg_r_acc2_grd,
    ppg_r_acc3_lo, ppg_r_acc3_hi, ppg_r_acc3_grd,
    ppg_r_trans0, ppg_r_trans1,
    ppg_r_circ_size03, ppg_r_circ_size47, ppg_r_circ_sizec,
    ppg_r_circ_start01, ppg_r_circ_start23, ppg_r_circ_start45,
    ppg_r_circ_start67, ppg_r_circ_startc,
    ppg_r_blk_cnt0, ppg_r_blk_cnt1, ppg_r_blk_save,
    ppg_r_rpt_start0, ppg_r_rpt_start1, ppg_r_rpt_end0, ppg_r_rpt_end1
  } ppg_reg_t;

  // Protected resource: a single register or a whole group
  typedef struct packed {
    logic grouped;
    logic [5:0] id;
  } ppg_key_t;

  // One register access of an instruction
  typedef struct packed {
    logic en;
    ppg_stage_t stage;
    ppg_key_t key;
    logic [`PPG_MASK_W-1:0] mask;
  } ppg_acc_t;

  // Contents of one pipeline stage
  typedef struct packed {
    logic valid;
    ppg_acc_t rd;
    ppg_acc_t wr;
  } ppg_slot_t;

endpackage

// File: logic/ppg_regs.svh
/*
  Constants of the pipeline protection interlock: widths, protection
  group codes and reset values.
  Assumes it is included by bare name and only once per compile unit.
*/
`ifndef PPG_REGS_SVH
`define PPG_REGS_SVH

// Number of pipeline stages, decode to write
`define PPG_STAGES 7
// Width of a field index inside a status register
`define PPG_FIELD_W 4
// Width of a field mask, one bit per field
`define PPG_MASK_W 16
// Width of the stall cycle counter
`define PPG_CNT_W 16

// Protection group codes for coarse register groups
`define PPG_GRP_ACC0 6'h01
`define PPG_GRP_ACC1 6'h02
`define PPG_GRP_ACC2 6'h03
`define PPG_GRP_ACC3 6'h04
`define PPG_GRP_TRANS 6'h05
`define PPG_GRP_CIRC 6'h06
`define PPG_GRP_LOOP 6'h07

// Reset values
`define PPG_READY_RST 1'b1
`define PPG_HOLD_RST 7'h00
`define PPG_VALID_RST 7'h00
`define PPG_CNT_RST 16'h0000

`endif

// File: tb/pipeline_protection_granularity_tb_top.sv
/* Directed bench for the interlock: issues instruction pairs, counts holds.
   Assumes ppg_pkg and the checker are compiled first. */
`timescale 1ns/1ps
module pipeline_protection_granularity_tb_top
  import ppg_pkg::*;
;
  logic core_clk = 0, rstn = 0, issue_valid = 0;
  logic rd_en = 0, rd_direct = 0, wr_en = 0, wr_direct = 0;
  logic [5:0] rd_reg = 0, wr_reg = 0;
  logic [3:0] rd_field = 0, wr_field = 0;
  logic [2:0] rd_stage = 0, wr_stage = 0;
  logic issue_ready;
  logic [6:0] stage_valid, stage_hold;
  logic [15:0] stall_count;
  int miscompares = 0, checks_done = 0;

  ppg_interlock u_dut (.core_clk, .rstn, .issue_valid, .rd_en, .rd_reg, .rd_direct, .rd_field,
    .rd_stage, .wr_en, .wr_reg, .wr_direct, .wr_field, .wr_stage, .issue_ready, .stage_valid,
    .stage_hold, .stall_count);

  // 100 MHz core clock
  always #5 core_clk = ~core_clk;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Packs one access: enable, register, direct, field, stage
  function automatic logic [14:0] acc(ppg_reg_t g, logic d, logic [3:0] f, ppg_stage_t s);
    return {1'b1, g, d, f, s};
  endfunction

  // Offers one instruction; returns just before the taking edge
  task automatic send(input logic [14:0] r, input logic [14:0] w);
    int n;
    @(negedge core_clk);
    {rd_en, rd_reg, rd_direct, rd_field, rd_stage} = r;
    {wr_en, wr_reg, wr_direct, wr_field, wr_stage} = w;
    issue_valid = 1'b1;
    n = 0;
    while (issue_ready !== 1'b1 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    if (issue_ready !== 1'b1)
    begin
      miscompares++;
      complete_run();
    end
  endtask

  // Writer then reader back to back; counts frozen cycles
  task automatic pair(input logic [14:0] w, input logic [14:0] r, input int exp_hold);
    int held;
    logic [15:0] base;
    base = stall_count;
    send(15'h0, w);
    send(r, 15'h0);
    @(negedge core_clk);
    issue_valid = 1'b0;
    held = 0;
    repeat (12)
    begin
      @(negedge core_clk);
      if (stage_hold !== 7'h0)
        held++;
    end
    check("hold cycles", exp_hold[15:0], held[15:0]);
    check("stall count", base + exp_hold[15:0], stall_count);
    check("drained", 16'h0, {9'h0, stage_valid});
  endtask

  task automatic t_reset();
    check("ready", 16'h1, {15'h0, issue_ready});
    check("valid", 16'h0, {9'h0, stage_valid});
    check("count", 16'h0, stall_count);
  endtask

  task automatic t_walk();
    send(15'h0, 15'h0);
    for (int k = 0; k < 8; k++)
    begin
      @(negedge core_clk);
      issue_valid = 1'b0;
      check("walk", (k < 7) ? (16'h1 << k) : 16'h0, {9'h0, stage_valid});
    end
  endtask

  task automatic t_groups();
    pair(acc(ppg_r_circ_start23, 1, 0, ppg_st_write), acc(ppg_r_circ_start01, 1, 0, ppg_st_read), 2);
    pair(acc(ppg_r_acc1_hi, 1, 0, ppg_st_write), acc(ppg_r_acc1_lo, 1, 0, ppg_st_read), 2);
    pair(acc(ppg_r_blk_cnt0, 1, 0, ppg_st_write), acc(ppg_r_rpt_end0, 1, 0, ppg_st_read), 2);
    pair(acc(ppg_r_trans1, 1, 0, ppg_st_write), acc(ppg_r_trans0, 1, 0, ppg_st_read), 2);
    pair(acc(ppg_r_acc0_lo, 1, 0, ppg_st_write), acc(ppg_r_trans0, 1, 0, ppg_st_read), 0);
    pair(acc(ppg_r_aux3, 1, 0, ppg_st_write), acc(ppg_r_aux4, 1, 0, ppg_st_read), 0);
  endtask

  task automatic t_status();
    pair(acc(ppg_r_stat0, 1, 0, ppg_st_exec), acc(ppg_r_stat0, 0, 1, ppg_st_read), 1);
    pair(acc(ppg_r_stat0, 0, 0, ppg_st_exec), acc(ppg_r_stat0, 0, 1, ppg_st_read), 0);
    pair(acc(ppg_r_stat2, 0, 0, ppg_st_exec), acc(ppg_r_stat2, 0, 1, ppg_st_read), 1);
    pair(acc(ppg_r_coef_ptr, 1, 0, ppg_st_exec), acc(ppg_r_aux1, 0, 0, ppg_st_addr), 0);
  endtask

  // Main sequence: two-cycle reset, then the scenarios
  initial
  begin
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    t_reset();
    t_walk();
    t_groups();
    t_status();
    complete_run();
  end
endmodule

// File: tb/ppg_sva.sv
/* Port checker for the interlock: occupancy flow, hold shape, stall count.
   Assumes it is bound onto ppg_interlock, all on core_clk. */
`timescale 1ns/1ps
module ppg_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic issue_valid,
  input wire logic issue_ready,
  input wire logic [6:0] stage_valid,
  input wire logic [6:0] stage_hold,
  input wire logic [15:0] stall_count
);
  // Stages that should move on, and stages that should keep content
  logic [5:0] moving;
  logic [6:0] kept;
  assign moving = stage_valid[5:0] & ~stage_hold[5:0];
  assign kept = stage_valid & stage_hold;
  reset_clear_a: assert property (@(posedge core_clk) !rstn |=> issue_ready && stage_valid == 7'h0 && stage_hold == 7'h0 && stall_count == 16'h0)
    else $error("reset state wrong");
  take_enter_a: assert property (@(posedge core_clk) disable iff (!rstn) issue_valid && issue_ready |=> stage_valid[0])
    else $error("taken instruction missing in stage 0");
  advance_a: assert property (@(posedge core_clk) disable iff (!rstn) moving != 6'h0 |=> (stage_valid[6:1] & $past(moving)) == $past(moving))
    else $error("unfrozen stage did not advance");
  hold_shape_a: assert property (@(posedge core_clk) disable iff (!rstn) (stage_hold & (stage_hold + 7'h1)) == 7'h0)
    else $error("frozen stages not a lower run");
  no_top_hold_a: assert property (@(posedge core_clk) disable iff (!rstn) !stage_hold[6])
    else $error("write stage frozen");
  frozen_stay_a: assert property (@(posedge core_clk) disable iff (!rstn) kept != 7'h0 |=> (stage_valid & $past(kept)) == $past(kept))
    else $error("frozen stage lost its instruction");
  count_step_a: assert property (@(posedge core_clk) disable iff (!rstn) $changed(stall_count) |-> stall_count == $past(stall_count) + 16'h1)
    else $error("stall count jumped");
  idle_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn) stage_valid == 7'h0 && !issue_valid |=> stage_valid == 7'h0 && stage_hold == 7'h0)
    else $error("activity from an empty pipeline");
endmodule

bind ppg_interlock ppg_sva u_sva (.core_clk, .rstn, .issue_valid, .issue_ready, .stage_valid,
  .stage_hold, .stall_count);
